// ### hw/srec_pkg.sv
package srec_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SREC_CTRL_OFF = 8'h00;  // go pulse, deactivate, 64-bit support
  localparam logic [7:0] SREC_STATUS_OFF = 8'h04;  // busy, done, fail, root, fail code
  localparam logic [7:0] SREC_EXEC_LO_OFF = 8'h08;  // executive-structure pointer
  localparam logic [7:0] SREC_EXEC_HI_OFF = 8'h0c;
  localparam logic [7:0] SREC_ENREG_LO_OFF = 8'h10;  // enable-region pointer
  localparam logic [7:0] SREC_ENREG_HI_OFF = 8'h14;
  localparam logic [7:0] SREC_CUR_LO_OFF = 8'h18;  // current-structure pointer
  localparam logic [7:0] SREC_CUR_HI_OFF = 8'h1c;
  localparam logic [7:0] SREC_LINK_LO_OFF = 8'h20;  // link-pointer field
  localparam logic [7:0] SREC_LINK_HI_OFF = 8'h24;
  localparam logic [7:0] SREC_XFER_LO_OFF = 8'h28;  // transfer pointer (read only)
  localparam logic [7:0] SREC_XFER_HI_OFF = 8'h2c;
  localparam logic [7:0] SREC_EXREV_OFF = 8'h30;  // first word of executive structure
  localparam logic [7:0] SREC_EXCTL_OFF = 8'h34;  // executive structure control bits
  localparam logic [7:0] SREC_INJ_OFF = 8'h38;  // injection information
  localparam logic [7:0] SREC_GUEST_OFF = 8'h3c;  // activity + interruptibility
  localparam logic [7:0] SREC_SYSMGMT_STATE_BASE_OFF = 8'h40;  // guest state-base field
  localparam logic [7:0] SREC_TMRVAL_OFF = 8'h44;  // timer-value field
  localparam logic [7:0] SREC_STBASE_OFF = 8'h48;  // loaded state base (read only)

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int SREC_CTRL_GO_BIT = 0;
  localparam int SREC_CTRL_DEACT_BIT = 1;
  localparam int SREC_CTRL_LM_BIT = 2;
  localparam int SREC_EXCTL_LAUNCHED_BIT = 0;
  localparam int SREC_EXCTL_TIMER_BIT = 1;
  localparam int SREC_EXCTL_VNMI_BIT = 2;
  localparam int SREC_INJ_VALID_BIT = 31;
  localparam int SREC_INJ_TYPE_HI = 10;
  localparam int SREC_INJ_TYPE_LO = 8;
  localparam int SREC_INJ_VEC_HI = 7;
  localparam int SREC_NMI_BLOCK_BIT = 3;
  localparam int SREC_SMI_BLOCK_BIT = 2;
  localparam int SREC_ALIGN_HI = 11;
  localparam int SREC_ACT_LO = 16;  // activity state in bits 17:16 of guest word

  localparam logic [2:0] SREC_TYPE_OTHER = 3'h7;
  localparam logic [2:0] SREC_TYPE_NMI = 3'h2;
  localparam logic [7:0] SREC_VEC_MTF = 8'h00;
  localparam logic [1:0] SREC_ACT_STARTUP_INTERPROCESSOR_WAIT = 2'h3;

  // parameterised width and reset values
  localparam int SREC_PA_WIDTH = 36;
  localparam logic [31:0] SREC_REVISION_ID = 32'h0000_0001;  // arbitrary value
  localparam logic [63:0] SREC_PTR_RST = 64'h0;
  localparam logic [31:0] SREC_WORD_RST = 32'h0;

  // failure codes
  localparam logic [3:0] SREC_F_NONE = 4'h0;
  localparam logic [3:0] SREC_F_ALIGN = 4'h1;
  localparam logic [3:0] SREC_F_WIDTH = 4'h2;
  localparam logic [3:0] SREC_F_REV = 4'h3;
  localparam logic [3:0] SREC_F_LAUNCH = 4'h4;
  localparam logic [3:0] SREC_F_DEACT = 4'h5;
  localparam logic [3:0] SREC_F_INJ = 4'h6;
  localparam logic [3:0] SREC_F_STARTUP_INTERPROCESSOR_WAIT = 4'h7;
  localparam logic [3:0] SREC_F_NMI = 4'h8;
  localparam logic [3:0] SREC_F_EXEC = 4'h9;

  // ---------------------------------------------------------------------------
  // sequencer states and grouped outputs
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    SREC_IDLE = 5'b00001,
    SREC_PTR = 5'b00010,
    SREC_CTL = 5'b00100,
    SREC_GST = 5'b01000,
    SREC_COMMIT = 5'b10000
  } srec_state_type;

  typedef struct packed {
    logic translation_cache_flush_all;
    logic timer_start;
    logic [31:0] timer_init;
    logic induced_exit_enable;
  } srec_effect_type;

endpackage

// ### hw/srec_checker.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - resume instruction: exit in guest mode, invalid-opcode in root mode, under dual monitor.
// - refuse the virtualization-disable instruction while dual monitor is active.
// - return is an entry with entry-to-management clear; it undoes the earlier exit.
// - executive pointer equal to enable-region pointer keeps the processor in root mode.
// - fail unless executive pointer bits 11:0 are zero.
// - fail on pointer bits above address width, or 63:32 without 64-bit support.
// - fail unless first word at executive pointer equals revision identifier.
// - pointer checks come before execution-control and launch/deactivate checks.
// - deactivate 0 needs launched executive; deactivate 1 needs pointer equal enable region.
// - execution-control checks skipped in root mode, else done on executive structure.
// - no check tying save-timer exit control to activate-timer control.
// - root-staying entry fails on valid injection unless type 7 vector 0.
// - root-staying entry fails when activity state is startup-message wait.
// - nmi-blocking check skipped in root mode, else uses executive virtual-nmi control.
// - load state base register from current structure guest field.
// - flush translation cache for every virtual-processor tag.
// - start timer only entering guest with executive timer control; value from current.
// - copy current pointer to transfer pointer, then load link or executive pointer.
// - after guest entry, execution controls come from the new current structure.
// - pointer swap precedes injection; injection uses controls of the original structure.
// - entry-induced exits only entering guest, decided by the new executive structure.
// - after keeping dual monitor, interrupt blocking follows interruptibility bit 2.
module srec_checker
  import srec_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic dual_monitor_in,
  input wire logic in_sysmgmt_in,
  input wire logic guest_mode_in,
  input wire logic resume_exec_in,
  input wire logic disable_exec_in,
  input wire logic entry_to_sysmgmt_in,
  input wire logic exec_ctl_ok_in,
  output logic resume_exit_out,
  output logic resume_ud_out,
  output logic disable_refused_out,
  output logic guest_mode_out,
  output logic sysmgmt_blocked_out,
  output logic inject_enable_out,
  output srec_effect_type effect_out
);

  // ---------------------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------------------
  typedef struct packed {
    // sequencer and bus capture
    srec_state_type st;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic deact;
    logic lm;
    // pointer fields
    logic [63:0] exec_ptr;
    logic [63:0] enreg_ptr;
    logic [63:0] cur_ptr;
    logic [63:0] link_ptr;
    logic [63:0] xfer_ptr;
    // executive and current structure fields
    logic [31:0] exrev;
    logic [31:0] exctl;
    logic [31:0] inj;
    logic [31:0] guest;
    logic [31:0] sysmgmt_state_base_fld;
    logic [31:0] tmrval;
    logic [31:0] state_base;
    // status and event outputs
    logic busy;
    logic done;
    logic fail;
    logic root;
    logic in_guest;  // last committed entry entered guest mode
    logic [3:0] code;
    logic inj_en;
    logic smi_blk;
    logic rex;
    logic rud;
    logic dref;
    srec_effect_type eff;
  } srec_regs_type;

  // registered state and its next value
  srec_regs_type r_q;
  srec_regs_type r_d;

  // decoded fields and helpers
  logic stay_root;
  logic [63:0] above_mask;
  logic inj_valid;
  logic [2:0] inj_type;
  logic [7:0] inj_vec;
  logic [31:0] rd_mux;
  logic [31:0] wword;
  logic word_xfer;

  // decision terms
  assign stay_root = (r_q.exec_ptr == r_q.enreg_ptr);
  // bits that must be clear: above the address width, or the upper half
  assign above_mask = r_q.lm ? ~((64'h1 << SREC_PA_WIDTH) - 64'h1) : 64'hffff_ffff_0000_0000;
  // injection information fields
  assign inj_valid = r_q.inj[SREC_INJ_VALID_BIT];
  assign inj_type = r_q.inj[SREC_INJ_TYPE_HI:SREC_INJ_TYPE_LO];
  assign inj_vec = r_q.inj[SREC_INJ_VEC_HI:0];
  assign wword = hwdata;
  // only whole-word transfers reach the register file
  assign word_xfer = (hsize == 3'h2);

  // bus slave handshake: one wait state on reads
  // read data is registered in the first data cycle and stands in the second
  assign hreadyout = ~r_q.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = r_q.rdata;

  // outputs from flip-flops
  assign resume_exit_out = r_q.rex;
  assign resume_ud_out = r_q.rud;
  assign disable_refused_out = r_q.dref;
  assign guest_mode_out = r_q.in_guest;  // held until the next commit
  assign sysmgmt_blocked_out = r_q.smi_blk;
  assign inject_enable_out = r_q.inj_en;
  assign effect_out = r_q.eff;

  // ---------------------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    unique case (r_q.addr)
      SREC_CTRL_OFF: rd_mux = {29'h0, r_q.lm, r_q.deact, 1'b0};
      SREC_STATUS_OFF: rd_mux = {24'h0, r_q.code, r_q.root, r_q.fail, r_q.done, r_q.busy};
      SREC_EXEC_LO_OFF: rd_mux = r_q.exec_ptr[31:0];
      SREC_EXEC_HI_OFF: rd_mux = r_q.exec_ptr[63:32];
      SREC_ENREG_LO_OFF: rd_mux = r_q.enreg_ptr[31:0];
      SREC_ENREG_HI_OFF: rd_mux = r_q.enreg_ptr[63:32];
      SREC_CUR_LO_OFF: rd_mux = r_q.cur_ptr[31:0];
      SREC_CUR_HI_OFF: rd_mux = r_q.cur_ptr[63:32];
      SREC_LINK_LO_OFF: rd_mux = r_q.link_ptr[31:0];
      SREC_LINK_HI_OFF: rd_mux = r_q.link_ptr[63:32];
      SREC_XFER_LO_OFF: rd_mux = r_q.xfer_ptr[31:0];
      SREC_XFER_HI_OFF: rd_mux = r_q.xfer_ptr[63:32];
      SREC_EXREV_OFF: rd_mux = r_q.exrev;
      SREC_EXCTL_OFF: rd_mux = r_q.exctl;
      SREC_INJ_OFF: rd_mux = r_q.inj;
      SREC_GUEST_OFF: rd_mux = r_q.guest;
      SREC_SYSMGMT_STATE_BASE_OFF: rd_mux = r_q.sysmgmt_state_base_fld;
      SREC_TMRVAL_OFF: rd_mux = r_q.tmrval;
      SREC_STBASE_OFF: rd_mux = r_q.state_base;
      default: rd_mux = SREC_WORD_RST;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    // hold everything unless a branch below changes it
    r_d = r_q;
    // one-cycle event pulses
    r_d.rex = 1'b0;
    r_d.rud = 1'b0;
    r_d.dref = 1'b0;
    r_d.eff.translation_cache_flush_all = 1'b0;
    r_d.eff.timer_start = 1'b0;

    // instruction intercepts under dual monitor
    if (dual_monitor_in && resume_exec_in) begin
      r_d.rex = in_sysmgmt_in & guest_mode_in;
      r_d.rud = ~guest_mode_in;
    end
    r_d.dref = dual_monitor_in & disable_exec_in;

    // bus address phase capture
    r_d.wr_pend = 1'b0;
    r_d.rd_pend = 1'b0;
    if (hsel && hready && htrans[1] && word_xfer) begin
      r_d.addr = haddr[7:0];
      r_d.wr_pend = hwrite;
      r_d.rd_pend = ~hwrite;
    end

    // read data phase
    // a status read clears done; a commit in the same cycle sets it again
    if (r_q.rd_pend) begin
      r_d.rdata = rd_mux;
      if (r_q.addr == SREC_STATUS_OFF) begin
        r_d.done = 1'b0;
      end
    end

    // write data phase
    if (r_q.wr_pend) begin
      unique case (r_q.addr)
        SREC_CTRL_OFF: begin
          r_d.deact = wword[SREC_CTRL_DEACT_BIT];
          r_d.lm = wword[SREC_CTRL_LM_BIT];
          // a go with entry-to-management set is not a return entry
          if (wword[SREC_CTRL_GO_BIT] && !r_q.busy && !entry_to_sysmgmt_in) begin
            r_d.st = SREC_PTR;
            r_d.busy = 1'b1;
            r_d.done = 1'b0;
            r_d.fail = 1'b0;
            r_d.code = SREC_F_NONE;
          end
        end
        // 64-bit pointers arrive as two words in either order
        SREC_EXEC_LO_OFF: r_d.exec_ptr[31:0] = wword;
        SREC_EXEC_HI_OFF: r_d.exec_ptr[63:32] = wword;
        SREC_ENREG_LO_OFF: r_d.enreg_ptr[31:0] = wword;
        SREC_ENREG_HI_OFF: r_d.enreg_ptr[63:32] = wword;
        SREC_CUR_LO_OFF: r_d.cur_ptr[31:0] = wword;
        SREC_CUR_HI_OFF: r_d.cur_ptr[63:32] = wword;
        SREC_LINK_LO_OFF: r_d.link_ptr[31:0] = wword;
        SREC_LINK_HI_OFF: r_d.link_ptr[63:32] = wword;
        SREC_EXREV_OFF: r_d.exrev = wword;
        SREC_EXCTL_OFF: r_d.exctl = wword;
        SREC_INJ_OFF: r_d.inj = wword;
        SREC_GUEST_OFF: r_d.guest = wword;
        SREC_SYSMGMT_STATE_BASE_OFF: r_d.sysmgmt_state_base_fld = wword;
        SREC_TMRVAL_OFF: r_d.tmrval = wword;
        default: begin
        end
      endcase
    end

    // entry sequencer
    // one stage per cycle; the first failing stage records its code and stops
    unique case (r_q.st)
      SREC_IDLE: begin
      end

      // pointer checks first, ahead of all others
      // alignment, then address width, then revision word
      SREC_PTR: begin
        r_d.st = SREC_CTL;
        if (r_q.exec_ptr[SREC_ALIGN_HI:0] != 12'h000) begin
          r_d.code = SREC_F_ALIGN;
        end else if ((r_q.exec_ptr & above_mask) != 64'h0) begin
          r_d.code = SREC_F_WIDTH;
        end else if (r_q.exrev != SREC_REVISION_ID) begin
          r_d.code = SREC_F_REV;
        end
        if (r_d.code != SREC_F_NONE) begin
          r_d.st = SREC_IDLE;
          r_d.fail = 1'b1;
          r_d.busy = 1'b0;
        end
      end

      // executive controls checked only when entering guest
      // launch state or deactivate condition come before the control checks
      SREC_CTL: begin
        r_d.st = SREC_GST;
        r_d.root = stay_root;
        if (!r_q.deact && !r_q.exctl[SREC_EXCTL_LAUNCHED_BIT]) begin
          r_d.code = SREC_F_LAUNCH;
        end else if (r_q.deact && !stay_root) begin
          r_d.code = SREC_F_DEACT;
        end else if (!stay_root && !exec_ctl_ok_in) begin
          r_d.code = SREC_F_EXEC;  // no save-timer pairing
        end
        if (r_d.code != SREC_F_NONE) begin
          r_d.st = SREC_IDLE;
          r_d.fail = 1'b1;
          r_d.busy = 1'b0;
        end
      end

      // injection and activity checks; nmi blocking only toward guest
      SREC_GST: begin
        r_d.st = SREC_COMMIT;
        if (stay_root && inj_valid
            && !(inj_type == SREC_TYPE_OTHER && inj_vec == SREC_VEC_MTF)) begin
          r_d.code = SREC_F_INJ;
        end else if (stay_root
                     && r_q.guest[SREC_ACT_LO+1:SREC_ACT_LO] == SREC_ACT_STARTUP_INTERPROCESSOR_WAIT) begin
          r_d.code = SREC_F_STARTUP_INTERPROCESSOR_WAIT;
        end else if (!stay_root && r_q.exctl[SREC_EXCTL_VNMI_BIT] && inj_valid
                     && inj_type == SREC_TYPE_NMI && r_q.guest[SREC_NMI_BLOCK_BIT]) begin
          r_d.code = SREC_F_NMI;
        end
        if (r_d.code != SREC_F_NONE) begin
          r_d.st = SREC_IDLE;
          r_d.fail = 1'b1;
          r_d.busy = 1'b0;
        end
      end

      // commit: reverse the earlier exit
      SREC_COMMIT: begin
        r_d.st = SREC_IDLE;
        r_d.busy = 1'b0;
        r_d.done = 1'b1;
        r_d.state_base = r_q.sysmgmt_state_base_fld;
        r_d.eff.translation_cache_flush_all = 1'b1;
        r_d.eff.timer_start = ~stay_root & r_q.exctl[SREC_EXCTL_TIMER_BIT];
        r_d.eff.timer_init = r_q.tmrval;
        r_d.xfer_ptr = r_q.cur_ptr;
        r_d.cur_ptr = stay_root ? r_q.link_ptr : r_q.exec_ptr;
        // injection rides on the original structure's fields, captured before swap
        r_d.inj_en = inj_valid;
        r_d.eff.induced_exit_enable = ~stay_root;
        r_d.in_guest = ~stay_root;
        r_d.smi_blk = r_q.deact ? 1'b0 : r_q.guest[SREC_SMI_BLOCK_BIT];
      end

      // illegal one-hot code: fall back to idle
      default: begin
        r_d.st = SREC_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  // synchronous reset; a low clock enable holds every field
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      r_q <= '0;
      r_q.st <= SREC_IDLE;
      r_q.enreg_ptr <= SREC_PTR_RST;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

endmodule // srec_checker

// ### dv/srec_asserts.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// intercept and entry-effect properties
// ---------------------------------------------------------------------------
module srec_asserts
  import srec_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic dual_monitor_in,
  input wire logic in_sysmgmt_in,
  input wire logic guest_mode_in,
  input wire logic resume_exec_in,
  input wire logic disable_exec_in,
  input wire logic resume_exit_out,
  input wire logic resume_ud_out,
  input wire logic disable_refused_out,
  input wire logic guest_mode_out,
  input wire srec_effect_type effect_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in || !clk_en_in);

  // resume instruction seen in each mode
  sequence s_resume_guest;
    dual_monitor_in && in_sysmgmt_in && guest_mode_in && resume_exec_in;
  endsequence
  sequence s_resume_root;
    dual_monitor_in && !guest_mode_in && resume_exec_in;
  endsequence

  a_resume_guest_exit: assert property (s_resume_guest |=> resume_exit_out)
    else $error("resume in guest mode gave no exit");
  a_resume_root_ud: assert property (s_resume_root |=> resume_ud_out)
    else $error("resume in root mode gave no invalid opcode");
  a_resume_one_kind: assert property (!(resume_exit_out && resume_ud_out))
    else $error("resume gave exit and invalid opcode together");
  a_disable_refused: assert property (dual_monitor_in && disable_exec_in |=>
      disable_refused_out)
    else $error("disable instruction not refused");
  a_flush_one_cycle: assert property ($rose(effect_out.translation_cache_flush_all) |=>
      !effect_out.translation_cache_flush_all)
    else $error("cache flush pulse longer than one cycle");
  a_timer_with_flush: assert property (effect_out.timer_start |->
      effect_out.translation_cache_flush_all)
    else $error("timer started without a committed entry");
  a_timer_guest_only: assert property (effect_out.timer_start |=> guest_mode_out)
    else $error("timer started on an entry that stays in root");
  a_exit_needs_guest: assert property (effect_out.induced_exit_enable |-> guest_mode_out)
    else $error("induced exits enabled outside guest mode");
  a_exit_at_commit: assert property ($rose(effect_out.induced_exit_enable) |->
      effect_out.translation_cache_flush_all)
    else $error("induced exits enabled away from a commit");
endmodule // srec_asserts

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import srec_pkg::*;
  logic clock_in = 0, rst_in = 1, clk_en_in = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, tinit, s;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic dual = 1, in_sm = 1, gm = 1, res = 0, dis = 0, e2s = 0, ok = 1;
  wire logic hready, hresp, guest_o, smib_o, inj_o, rx_o, ud_o, ref_o;
  wire logic [31:0] hrdata;
  wire srec_effect_type eff;
  int fail_count = 0, compares = 0, flushes = 0, starts = 0, cyc = 0;
  localparam logic [31:0] LNCH = 32'h1, TMR = 32'h2, VNMI = 32'h4;

  always #2.5 clock_in = ~clock_in;

  srec_checker uut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .dual_monitor_in(dual), .in_sysmgmt_in(in_sm), .guest_mode_in(gm), .resume_exec_in(res),
    .disable_exec_in(dis), .entry_to_sysmgmt_in(e2s), .exec_ctl_ok_in(ok),
    .resume_exit_out(rx_o), .resume_ud_out(ud_o), .disable_refused_out(ref_o),
    .guest_mode_out(guest_o), .sysmgmt_blocked_out(smib_o), .inject_enable_out(inj_o),
    .effect_out(eff));

  // pulse counters and hang limit
  always @(posedge clock_in) begin
    cyc++;
    if (eff.translation_cache_flush_all === 1'b1) flushes++;
    if (eff.timer_start === 1'b1) starts++;
    if (eff.timer_start === 1'b1) tinit = eff.timer_init;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task check(input string n, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one single word transfer; read data taken at the data-phase ready edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_in); while (hready !== 1'b1);
    s = hrdata;
  endtask

  task rd_chk(input logic [7:0] a, input string n, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, s, e);
  endtask

  // set up fields, start an entry, poll status, judge fail flag and code
  task entry(input logic [63:0] ex, input logic [31:0] ctl, input logic [31:0] xc,
             input logic [31:0] inj, input logic [31:0] gst, input logic [3:0] code);
    int n;
    bus(1'b1, SREC_EXEC_LO_OFF, ex[31:0]);
    bus(1'b1, SREC_EXEC_HI_OFF, ex[63:32]);
    bus(1'b1, SREC_EXCTL_OFF, xc);
    bus(1'b1, SREC_INJ_OFF, inj);
    bus(1'b1, SREC_GUEST_OFF, gst);
    bus(1'b1, SREC_CTRL_OFF, ctl | 32'h1);
    n = 0;
    do begin
      bus(1'b0, SREC_STATUS_OFF, 32'h0);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    check("status code", {s[7:4], s[2]}, {code, code != SREC_F_NONE});
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task t_intercept;
    @(posedge clock_in) res <= 1'b1;
    @(posedge clock_in) res <= 1'b0;
    #1 check("guest resume", {rx_o, ud_o}, 2'b10);
    gm <= 1'b0;
    @(posedge clock_in) res <= 1'b1;
    @(posedge clock_in) res <= 1'b0;
    #1 check("root resume", {rx_o, ud_o}, 2'b01);
    @(posedge clock_in) dis <= 1'b1;
    @(posedge clock_in) dis <= 1'b0;
    #1 check("disable refused", ref_o, 1'b1);
    // a low clock enable must hold the pulse registers
    @(posedge clock_in) begin
      clk_en_in <= 1'b0;
      res <= 1'b1;
    end
    @(posedge clock_in) res <= 1'b0;
    #1 check("frozen resume", ud_o, 1'b0);
    @(posedge clock_in) clk_en_in <= 1'b1;
  endtask

  task t_pointer;
    bus(1'b1, SREC_ENREG_LO_OFF, 32'h1000);
    bus(1'b1, SREC_EXREV_OFF, SREC_REVISION_ID);
    entry(64'h3004, 0, LNCH, 0, 0, SREC_F_ALIGN);
    entry(64'h1_0000_3000, 0, LNCH, 0, 0, SREC_F_WIDTH);
    entry(64'h1_0000_3000, 32'h4, 0, 0, 0, SREC_F_LAUNCH);
    entry(64'h10_0000_3000, 32'h4, LNCH, 0, 0, SREC_F_WIDTH);
    bus(1'b1, SREC_EXREV_OFF, ~SREC_REVISION_ID);
    entry(64'h3000, 0, LNCH, 0, 0, SREC_F_REV);
    entry(64'h3004, 0, 0, 0, 0, SREC_F_ALIGN);
    bus(1'b1, SREC_EXREV_OFF, SREC_REVISION_ID);
    entry(64'h3000, 32'h2, LNCH, 0, 0, SREC_F_DEACT);
  endtask

  task t_root;
    bus(1'b1, SREC_CUR_LO_OFF, 32'h5000);
    bus(1'b1, SREC_LINK_LO_OFF, 32'h7000);
    bus(1'b1, SREC_SYSMGMT_STATE_BASE_OFF, 32'ha000);
    bus(1'b1, SREC_TMRVAL_OFF, 32'h55);
    ok <= 1'b0;
    entry(64'h1000, 0, LNCH, 32'h8000_0200, 0, SREC_F_INJ);
    entry(64'h1000, 0, LNCH, 32'h8000_0700, 32'h3_0000, SREC_F_STARTUP_INTERPROCESSOR_WAIT);
    entry(64'h1000, 0, LNCH | TMR, 32'h8000_0700, 32'hc, SREC_F_NONE);
    check("root stay", s[3], 1'b1);
    rd_chk(SREC_XFER_LO_OFF, "transfer ptr", 32'h5000);
    rd_chk(SREC_CUR_LO_OFF, "current ptr", 32'h7000);
    rd_chk(SREC_STBASE_OFF, "state base", 32'ha000);
    check("root guest", {guest_o, eff.induced_exit_enable}, 2'b00);
    check("root flushes", {flushes[7:0], starts[7:0]}, 16'h0100);
    check("root blocking", {smib_o, inj_o}, 2'b11);
  endtask

  task t_guest;
    entry(64'h3000, 0, LNCH, 0, 0, SREC_F_EXEC);
    ok <= 1'b1;
    entry(64'h3000, 0, LNCH | VNMI, 32'h8000_0200, 32'h8, SREC_F_NMI);
    entry(64'h3000, 0, LNCH | TMR, 32'h8000_0200, 32'h8, SREC_F_NONE);
    rd_chk(SREC_XFER_LO_OFF, "transfer ptr", 32'h7000);
    rd_chk(SREC_CUR_LO_OFF, "current ptr", 32'h3000);
    check("guest entry", {guest_o, eff.induced_exit_enable, smib_o}, 3'b110);
    check("guest counts", {flushes[7:0], starts[7:0]}, 16'h0201);
    check("guest timer value", tinit, 32'h55);
  endtask

  task t_gate;
    e2s <= 1'b1;
    bus(1'b1, SREC_CTRL_OFF, 32'h1);
    repeat (8) @(posedge clock_in);
    check("gated go", flushes, 2);
    e2s <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    check("reset outputs", {guest_o, smib_o, inj_o, rx_o, ud_o, ref_o, hresp, eff}, 0);
    t_intercept;
    t_pointer;
    t_root;
    t_guest;
    t_gate;
    test_done;
  end
endmodule // tb_top

bind srec_checker srec_asserts u_asrt (.clock_in(clock_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in),
  .dual_monitor_in(dual_monitor_in), .in_sysmgmt_in(in_sysmgmt_in),
  .guest_mode_in(guest_mode_in), .resume_exec_in(resume_exec_in),
  .disable_exec_in(disable_exec_in), .resume_exit_out(resume_exit_out),
  .resume_ud_out(resume_ud_out), .disable_refused_out(disable_refused_out),
  .guest_mode_out(guest_mode_out), .effect_out(effect_out));
